// >>> hw/agl_autorange.sv
/*
 * Autoranging gain and display control logic with its processor-side
 * register file on APB. Holds the input-stage and distortion amplifier gain
 * counters, their decoders, the gain adder and display selectors, the switch
 * selector, the addressable latch, the octal control register, the memory
 * decode and a small talker/listener address tracker.
 * Assumes comparators and panel inputs are synchronous levels that may still
 * glitch, one 100 MHz clock pclk, and an APB master in the usual style.
 */
// Implementation choices: the APB slave port and the register addresses.
// Summary of operation
// [R1] Manual ranging presets input counter from panel switch.
// [R2] Automatic ranging steps input counter on comparators.
// [R3] Input counter decoded one-hot onto gain lines.
// [R4] Over-level counts the input counter down.
// [R5] Count only when not already at limit.
// [R6] Range lights follow gating, distortion too in level.
// [R7] Odd ten dB step flag feeds distortion and adder.
// [R8] Distortion counter ranges like input counter.
// [R9] Mode selects level or distortion switches for distortion.
// [R10] Distortion counter decoded three-to-eight one-hot.
// [R11] Adder sums four-bit and two-bit gain codes.
// [R12] Gain sum lights exactly one unit annunciator.
// [R13] Decimal point source chosen by mode, dB fixed.
// [R14] Offset code from sum or distortion gain.
// [R15] Three-bit select returns one of eight inputs.
// [R16] Addressable latch lines override panel filter switches.
// [R17] Address switch read only while both enables low.
// [R18] Octal register drives inverted open-collector control lines.
// [R19] Byte data, 16-bit addresses, RAM and ROM decode.
// [R20] Talker and listener addressing handled automatically.
// [R21] Comparators synchronised, one step per event.
`timescale 1ns/1ps
`include "agl_consts.svh"

module agl_autorange (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire agl_pkg::agl_cmp_type cmp,
   input wire agl_pkg::agl_panel_type panel,
   input wire agl_pkg::agl_drive_type drive,
   input wire logic [15:0] cpu_addr,
   input wire logic bus_cmd_valid,
   input wire logic [7:0] bus_cmd,
   output logic [9:0] in_gain_lines,
   output logic [7:0] dist_gain_lines,
   output logic [3:0] dist_gain_src,
   output logic odd_step,
   output agl_pkg::agl_disp_type disp,
   output logic [3:0] filter_lines,
   output logic [3:0] drive_lines,
   output logic [7:0] ctrl_line_o,
   output logic [7:0] ctrl_line_oe,
   output logic ram_sel,
   output logic rom_sel,
   output logic talker,
   output logic listener
);
   import agl_pkg::*;

   agl_mode_type mode_q;
   logic [7:0] octal_q;
   logic [7:0] latch_q;
   logic [7:0] latch_written_q;
   logic [2:0] swsel_q;
   logic [3:0] in_q;
   logic [2:0] dist_q;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] prev_q;
   logic talker_q;
   logic listener_q;
   logic auto_mode;
   logic level_mode;
   logic in_over;
   logic in_under;
   logic dist_over;
   logic dist_under;
   logic in_up_ok;
   logic in_dn_ok;
   logic dist_up_ok;
   logic dist_dn_ok;
   logic [3:0] rise;
   logic [4:0] gain_sum;
   logic [3:0] sel_data;
   logic sw_bit;
   logic addr_buf_en1_n;
   logic addr_buf_en2_n;
   logic [31:0] rd_d;
   logic rd_err;
   logic wr_en;
   logic rd_en;

   // Every access completes in its first access cycle.
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   // Read select spans setup and access, since read data is taken at setup.
   assign rd_en = psel & ~pwrite;

   // Control register holds the measurement mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= AGL_MODE_VOLTS;
      end else if (wr_en && paddr == `AGL_OFF_CTRL) begin
         mode_q <= agl_mode_type'(pwdata[`AGL_CTRL_MODE_MSB:`AGL_CTRL_MODE_LSB]);
      end
   end

   // Octal register captures processor writes for the control lines.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         octal_q <= `AGL_OCT_RESET;
      end else if (wr_en && paddr == `AGL_OFF_OCTAL) begin
         octal_q <= pwdata[7:0]; // [R18]
      end
   end

   // Inverting open-collector stage: a set bit pulls its line low.
   assign ctrl_line_o = 8'h00; // [R18]
   assign ctrl_line_oe = octal_q; // [R18]
   assign auto_mode = octal_q[`AGL_OCT_AUTO_BIT]; // [R18]

   // Switch selector code written by the processor.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swsel_q <= 3'h0;
      end else if (wr_en && paddr == `AGL_OFF_SWSEL) begin
         swsel_q <= pwdata[2:0]; // [R15]
      end
   end

   // Addressable latch: one line written per access, others kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 8'h00;
         latch_written_q <= 8'h00;
      end else if (wr_en && paddr == `AGL_OFF_LATCH) begin
         latch_q[pwdata[`AGL_LAT_SEL_MSB:`AGL_LAT_SEL_LSB]] <= pwdata[`AGL_LAT_DATA_BIT]; // [R16]
         latch_written_q[pwdata[`AGL_LAT_SEL_MSB:`AGL_LAT_SEL_LSB]] <= 1'b1;
      end
   end

   // Latched lines win over the panel once the processor has set them;
   // until then the panel switch passes straight through.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_filter
         assign filter_lines[gi] = latch_written_q[gi] ? latch_q[gi] : panel.filter[gi]; // [R16]
      end
   endgenerate
   assign drive_lines = latch_q[7:4]; // [R16]

   // Eight-way selector: filters on codes 0-3, drive inputs on 4-7.
   assign sel_data = {drive.level, drive.signal_noise_ratio_line,
                      drive.response, drive.mode_defeat};
   assign sw_bit = swsel_q[2] ? sel_data[swsel_q[1:0]] : filter_lines[swsel_q[1:0]]; // [R15]

   // Comparators pass two flops before anything looks at them; a third flop
   // gives edge detection so a held level steps the counter only once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 4'hF;
         sync2_q <= 4'hF;
         prev_q <= 4'hF;
      end else begin
         sync1_q <= cmp; // [R21]
         sync2_q <= sync1_q; // [R21]
         prev_q <= sync2_q;
      end
   end

   // Falling edge of an active-low comparator is one qualified event.
   assign rise = prev_q & ~sync2_q; // [R21]
   assign in_over = ~sync2_q[3];
   assign in_under = ~sync2_q[2];
   assign dist_over = ~sync2_q[1];
   assign dist_under = ~sync2_q[0];

   // Gating: over-level only counts above the least sensitive range, under-level
   // only below the most sensitive; over-level wins if both are seen.
   assign in_dn_ok = in_over && in_q != `AGL_IN_MIN; // [R5]
   assign in_up_ok = !in_over && in_under && in_q != `AGL_IN_MAX; // [R5]
   assign dist_dn_ok = dist_over && dist_q != `AGL_DIST_MIN; // [R8]
   assign dist_up_ok = !dist_over && dist_under && dist_q != `AGL_DIST_MAX; // [R8]

   // Input-stage gain counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_q <= `AGL_IN_MIN;
      end else if (!auto_mode) begin
         if (panel.preset_en) begin
            in_q <= {1'b0, panel.range}; // [R1]
         end
      end else if (rise[3] && in_dn_ok) begin
         in_q <= in_q - 4'h1; // [R4]
      end else if (rise[2] && in_up_ok) begin
         in_q <= in_q + 4'h1; // [R2]
      end
   end

   // Level mode uses the input range switch, distortion modes their own.
   assign level_mode = (mode_q == AGL_MODE_VOLTS) || (mode_q == AGL_MODE_LEVEL_DB);
   assign dist_gain_src = level_mode ? {1'b0, panel.range} : panel.dist_range; // [R9]

   // Distortion amplifier counter ranges like the input stage, but over eight ranges (0-7) instead of ten.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dist_q <= `AGL_DIST_MIN;
      end else if (!auto_mode) begin
         if (panel.preset_en) begin
            dist_q <= dist_gain_src[2:0]; // [R9]
         end
      end else if (rise[1] && dist_dn_ok) begin
         dist_q <= dist_q - 3'h1; // [R8]
      end else if (rise[0] && dist_up_ok) begin
         dist_q <= dist_q + 3'h1; // [R8]
      end
   end

   // Binary to one-of-N decoders drive the gain control lines.
   generate
      for (gi = 0; gi < 10; gi++) begin : g_in_dec
         assign in_gain_lines[gi] = (in_q == 4'(gi)); // [R3]
      end
      for (gi = 0; gi < 8; gi++) begin : g_dist_dec
         assign dist_gain_lines[gi] = (dist_q == 3'(gi)); // [R10]
      end
   endgenerate

   // Odd ten dB step of the input stage.
   assign odd_step = in_q[0]; // [R7]

   // Overall gain: four-bit input code plus two-bit distortion code.
   assign gain_sum = {1'b0, in_q} + {3'h0, dist_q[1:0]}; // [R11]

   // Display decode is registered so the data outputs come from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp <= '0;
      end else begin
         // Units: high gain means small signals.
         if (gain_sum >= `AGL_SUM_UV_MIN) begin
            disp.units <= 3'h1; // [R12]
         end else if (gain_sum >= `AGL_SUM_MV_MIN) begin
            disp.units <= 3'h2; // [R12]
         end else begin
            disp.units <= 3'h4; // [R12]
         end
         // Decimal point source per mode; dB modes force a fixed point.
         case (mode_q)
            AGL_MODE_VOLTS: begin
               disp.dp <= 3'(3'h1 << (gain_sum % `AGL_DP_STEPS)); // [R13] [R7]
               disp.dp_fixed <= 1'b0;
            end
            AGL_MODE_DIST_PCT: begin
               disp.dp <= 3'(3'h1 << ({2'h0, dist_q} % `AGL_DP_STEPS)); // [R13]
               disp.dp_fixed <= 1'b0;
            end
            default: begin
               disp.dp <= `AGL_DP_DB; // [R13]
               disp.dp_fixed <= 1'b1;
            end
         endcase
         // Offset generator code: gain sum in level, distortion gain otherwise.
         if (level_mode) begin
            disp.offset <= 3'(gain_sum % `AGL_OFS_TAPS); // [R14]
         end else begin
            disp.offset <= 3'({2'h0, dist_q} % `AGL_OFS_TAPS); // [R14]
         end
         // Range lights follow the gating; level mode adds the distortion side.
         disp.over_led <= in_dn_ok | (level_mode & dist_dn_ok); // [R6]
         disp.under_led <= in_up_ok | (level_mode & dist_up_ok); // [R6]
      end
   end

   // Memory decode of the processor's 16-bit address space.
   assign ram_sel = cpu_addr <= `AGL_RAM_TOP; // [R19]
   assign rom_sel = cpu_addr >= `AGL_ROM_BASE; // [R19]

   // Talker/listener addressing: commands carry the 5-bit address in the low
   // bits; unlisten and untalk release the roles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         talker_q <= 1'b0;
         listener_q <= 1'b0;
      end else if (bus_cmd_valid) begin
         if (bus_cmd == `AGL_CMD_UNL) begin
            listener_q <= 1'b0; // [R20]
         end else if (bus_cmd == `AGL_CMD_UNT) begin
            talker_q <= 1'b0; // [R20]
         end else if (bus_cmd[4:0] == panel.bus_addr) begin
            if (bus_cmd[7:5] == `AGL_CMD_LISTEN) begin
               listener_q <= 1'b1; // [R20]
            end else if (bus_cmd[7:5] == `AGL_CMD_TALK) begin
               talker_q <= 1'b1; // [R20]
               listener_q <= 1'b0;
            end
         end else if (bus_cmd[7:5] == `AGL_CMD_TALK) begin
            talker_q <= 1'b0; // Another talker takes the bus.
         end
      end
   end
   assign talker = talker_q;
   assign listener = listener_q;

   // Address switch buffer is enabled for the whole read of its register,
   // setup cycle included, because read data is captured there.
   assign addr_buf_en1_n = ~(rd_en && paddr == `AGL_OFF_ADDRSW);
   assign addr_buf_en2_n = ~psel;

   // Read multiplexer; unmapped offsets answer zero with an error.
   always_comb begin
      rd_d = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `AGL_OFF_CTRL: rd_d[`AGL_CTRL_MODE_MSB:`AGL_CTRL_MODE_LSB] = mode_q;
         `AGL_OFF_STATUS: begin
            rd_d[`AGL_ST_IN_LSB +: 4] = in_q;
            rd_d[`AGL_ST_DIST_LSB +: 3] = dist_q;
            rd_d[`AGL_ST_SUM_LSB +: 5] = gain_sum;
            rd_d[`AGL_ST_ODD_BIT] = odd_step;
            rd_d[`AGL_ST_OVER_BIT] = in_over;
            rd_d[`AGL_ST_UNDER_BIT] = in_under;
         end
         `AGL_OFF_SWSEL: rd_d[0] = sw_bit; // [R15]
         `AGL_OFF_LATCH: rd_d[7:0] = latch_q;
         `AGL_OFF_OCTAL: rd_d[7:0] = octal_q;
         `AGL_OFF_ADDRSW: begin
            if (!addr_buf_en1_n && !addr_buf_en2_n) begin
               rd_d[4:0] = panel.bus_addr; // [R17]
            end
         end
         `AGL_OFF_BUSST: begin
            rd_d[`AGL_BS_TALK_BIT] = talker_q;
            rd_d[`AGL_BS_LISTEN_BIT] = listener_q;
         end
         `AGL_OFF_MEMDEC: rd_d[1:0] = {rom_sel, ram_sel};
         default: rd_err = 1'b1;
      endcase
   end

   // Read data is held in a flop so it stays stable between accesses.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_d;
      end
   end

   assign pslverr = psel & penable & rd_err;
endmodule

// >>> hw/agl_consts.svh
/*
 * Constants of the autoranging gain and display control block: register
 * offsets, field positions, reset values, counter limits and decode limits.
 * Assumes inclusion by its bare name from the package and the design module.
 */
`ifndef AGL_CONSTS_SVH
`define AGL_CONSTS_SVH

// Register byte offsets on the APB side.
`define AGL_OFF_CTRL 12'h000
`define AGL_OFF_STATUS 12'h004
`define AGL_OFF_SWSEL 12'h008
`define AGL_OFF_LATCH 12'h00C
`define AGL_OFF_OCTAL 12'h010
`define AGL_OFF_ADDRSW 12'h014
`define AGL_OFF_BUSST 12'h018
`define AGL_OFF_MEMDEC 12'h01C

// Control register fields.
`define AGL_CTRL_MODE_LSB 0
`define AGL_CTRL_MODE_MSB 1
`define AGL_CTRL_RESET 32'h0000_0000

// Addressable latch write fields: line select and data bit.
`define AGL_LAT_SEL_LSB 0
`define AGL_LAT_SEL_MSB 2
`define AGL_LAT_DATA_BIT 3

// Octal register: bit that turns automatic ranging on.
`define AGL_OCT_AUTO_BIT 0
`define AGL_OCT_RESET 8'h00

// Status register field positions.
`define AGL_ST_IN_LSB 0
`define AGL_ST_DIST_LSB 4
`define AGL_ST_SUM_LSB 8
`define AGL_ST_ODD_BIT 13
`define AGL_ST_OVER_BIT 14
`define AGL_ST_UNDER_BIT 15

// Bus controller status bits.
`define AGL_BS_TALK_BIT 0
`define AGL_BS_LISTEN_BIT 1

// Input-stage counter: 0 is the least sensitive range.
`define AGL_IN_MIN 4'h0
`define AGL_IN_MAX 4'h9
// Distortion amplifier counter limits.
`define AGL_DIST_MIN 3'h0
`define AGL_DIST_MAX 3'h7

// Gain sum decode limits for the unit annunciators.
`define AGL_SUM_UV_MIN 5'h0A
`define AGL_SUM_MV_MIN 5'h04
// Offset generator has six taps plus ground.
`define AGL_OFS_TAPS 5'h07
// Decimal point pattern forced on in the dB modes.
`define AGL_DP_DB 3'h2
`define AGL_DP_STEPS 5'h03

// Instrument bus commands.
`define AGL_CMD_LISTEN 3'h1
`define AGL_CMD_TALK 3'h2
`define AGL_CMD_UNL 8'h3F
`define AGL_CMD_UNT 8'h5F

// Processor memory map.
`define AGL_RAM_BASE 16'h0000
`define AGL_RAM_TOP 16'h03FF
`define AGL_ROM_BASE 16'hE000
`define AGL_ROM_TOP 16'hFFFF

`endif

// >>> hw/agl_pkg.sv
/*
 * Types of the autoranging gain and display control block.
 * Assumes the constants header is reachable by bare name.
 */
package agl_pkg;
   `include "agl_consts.svh"

   // Measurement modes; level modes are volts and dB level.
   typedef enum logic [1:0] {
      AGL_MODE_VOLTS,
      AGL_MODE_LEVEL_DB,
      AGL_MODE_DIST_PCT,
      AGL_MODE_DIST_DB
   } agl_mode_type;

   // Level comparators, active low as the detectors deliver them.
   typedef struct packed {
      logic in_over_n;
      logic in_under_n;
      logic dist_over_n;
      logic dist_under_n;
   } agl_cmp_type;

   // Front panel switches.
   typedef struct packed {
      logic [2:0] range;
      logic preset_en;
      logic [3:0] dist_range;
      logic [3:0] filter;
      logic [4:0] bus_addr;
   } agl_panel_type;

   // Drive inputs read back through the switch selector.
   typedef struct packed {
      logic mode_defeat;
      logic response;
      logic signal_noise_ratio_line;
      logic level;
   } agl_drive_type;

   // Display control outputs.
   typedef struct packed {
      logic [2:0] units;
      logic [2:0] dp;
      logic dp_fixed;
      logic [2:0] offset;
      logic over_led;
      logic under_led;
   } agl_disp_type;
endpackage

// >>> tb/agl_chk.sv
/* Port checker of the gain block: decoders, ranging steps and display selection.
   Assumes it is bound onto agl_autorange and sees only that module's ports. */
`timescale 1ns/1ps
`include "agl_consts.svh"
module agl_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire agl_pkg::agl_cmp_type cmp,
   input wire agl_pkg::agl_panel_type panel,
   input wire logic [9:0] in_gain_lines,
   input wire logic [7:0] dist_gain_lines,
   input wire logic [3:0] dist_gain_src,
   input wire logic odd_step,
   input wire agl_pkg::agl_disp_type disp,
   input wire logic [7:0] ctrl_line_oe
);
   import agl_pkg::*;
   logic [1:0] mode_q;
   logic auto_q;
   wire wr = psel && penable && pwrite;

   // Shadow of mode and ranging switch, written at the same edge as the block's own copy.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 2'h0;
         auto_q <= 1'b0;
      end else if (wr && paddr == `AGL_OFF_CTRL) begin
         mode_q <= pwdata[1:0];
      end else if (wr && paddr == `AGL_OFF_OCTAL) begin
         auto_q <= pwdata[`AGL_OCT_AUTO_BIT];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A range change made while automatic ranging was already on at that edge.
   sequence s_step;
      $past(auto_q) && $changed(in_gain_lines);
   endsequence
   sequence s_down;
      s_step ##0 (in_gain_lines < $past(in_gain_lines));
   endsequence

   AST_DECODE:
      assert property ($onehot(in_gain_lines) && $onehot(dist_gain_lines)
         && odd_step == |(in_gain_lines & 10'h2AA)) else $error("Gain decode wrong");
   AST_PRESET:
      assert property (panel.preset_en && !auto_q
         |=> in_gain_lines == 10'h001 << $past(panel.range))
      else $error("Preset not loaded");
   AST_STEP:
      assert property (s_step |-> in_gain_lines == $past(in_gain_lines) << 1
         || in_gain_lines == $past(in_gain_lines) >> 1) else $error("Range jumped");
   AST_DOWN:
      assert property (s_down |-> !$past(cmp.in_over_n, 2) || !$past(cmp.in_over_n, 3)
         || !$past(cmp.in_over_n, 4)) else $error("Step down without over level");
   AST_SRC:
      assert property (dist_gain_src == (mode_q[1] ? panel.dist_range : {1'b0, panel.range}))
      else $error("Distortion source wrong");
   AST_UNITS:
      assert property ($past(presetn) |-> $onehot(disp.units)) else $error("Unit lamps wrong");
   AST_DB_DP:
      assert property (mode_q[0] |=> disp.dp_fixed && disp.dp == `AGL_DP_DB)
      else $error("Fixed decimal point missing");
   AST_OCTAL:
      assert property (wr && paddr == `AGL_OFF_OCTAL |=> ctrl_line_oe == $past(pwdata[7:0]))
      else $error("Octal outputs wrong");
endmodule

bind agl_autorange agl_chk u_chk (.*);

// >>> tb/agl_far_model.sv
/* Far-side model: the four level comparators, high while no level event.
   Assumes the bench commands each event by calling pulse. */
`timescale 1ns/1ps
module agl_far_model (
   input wire logic pclk,
   output agl_pkg::agl_cmp_type cmp
);
   import agl_pkg::*;
   initial cmp = 4'hF;

   // Holds one comparator low for n cycles; even a one-cycle span passes the sync flops and counts as an event.
   task automatic pulse(input int idx, input int n);
      @(posedge pclk);
      cmp[idx] <= 1'b0;
      repeat (n) @(posedge pclk);
      cmp[idx] <= 1'b1;
   endtask
endmodule

// >>> tb/tb_top.sv
/* Bench of the gain block: APB master, panel and bus stimulus, comparators from the model.
   Assumes package, design, checker and model are compiled first. */
`timescale 1ns/1ps
`include "agl_consts.svh"
module tb_top;
   import agl_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_cmd_valid, odd_step;
   logic ram_sel, rom_sel, talker, listener, err_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cpu_addr;
   logic [7:0] bus_cmd, dist_gain_lines, ctrl_line_oe, ctrl_line_o, lat;
   logic [9:0] in_gain_lines;
   logic [3:0] dist_gain_src, filter_lines, drive_lines, ds;
   logic [2:0] r;
   logic [4:0] s;
   logic [15:0] corner [4] = '{16'h03FF, 16'h0400, 16'hDFFF, 16'hE000};
   logic [7:0] bcmd [7] = '{8'h20, 8'h3F, 8'h40, 8'h40, 8'h20, 8'h40, 8'h5F};
   logic [1:0] bexp [7] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b01, 2'b10, 2'b00};
   agl_cmp_type cmp;
   agl_panel_type panel;
   agl_drive_type drive;
   agl_disp_type disp;
   int errors;
   int check_count;

   agl_autorange DUT (.*);
   agl_far_model u_far (.pclk(pclk), .cmp(cmp));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One zero-or-more wait APB transfer, then one idle cycle so drivers never clash.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Expected {units, dp, dp_fixed, offset} for a mode, gain sum and distortion gain.
   function automatic logic [9:0] f_disp(input logic [1:0] m, input logic [4:0] sm,
      input logic [2:0] d);
      logic [2:0] u;
      u = (sm >= 5'h0A) ? 3'h1 : (sm >= 5'h04) ? 3'h2 : 3'h4;
      if (m[0]) return {u, 3'h2, 1'b1, 3'(m[1] ? d % 7 : sm % 7)};
      return {u, m[1] ? 3'h1 << (d % 3) : 3'h1 << (sm % 3), 1'b0, 3'(m[1] ? d % 7 : sm % 7)};
   endfunction

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      final_report;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {panel, drive, cpu_addr, bus_cmd_valid, bus_cmd} = '0;
      errors = 0;
      check_count = 0;
      void'($urandom(81771));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Manual ranging in every mode with random switch settings.
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, `AGL_OFF_CTRL, i % 4);
         panel.range <= 3'($urandom);
         panel.dist_range <= 4'($urandom);
         panel.preset_en <= 1'b1;
         repeat (3) @(posedge pclk);
         r = panel.range;
         ds = i[1] ? panel.dist_range : {1'b0, r};
         s = 5'(r) + 5'(ds[1:0]);
         chk(in_gain_lines, 10'h001 << r);
         chk(odd_step, r[0]);
         chk(dist_gain_src, ds);
         chk(dist_gain_lines, 8'h01 << ds[2:0]);
         chk(disp[11:2], f_disp(2'(i), s, ds[2:0]));
         apb(1'b0, `AGL_OFF_STATUS, 32'h0);
         chk(rd[12:8], s);
      end
      // Automatic ranging: one step per event, held at both limits; the comparator hold length varies.
      apb(1'b1, `AGL_OFF_CTRL, 32'h2);
      panel.range <= 3'h1;
      panel.dist_range <= 4'h3;
      repeat (3) @(posedge pclk);
      panel.preset_en <= 1'b0;
      apb(1'b1, `AGL_OFF_OCTAL, 32'h1);
      for (int k = 0; k < 12; k++) begin
         u_far.pulse(k < 2 ? 3 : 2, 4 + $urandom_range(4));
         repeat (5) @(posedge pclk);
         chk(in_gain_lines, 10'h001 << (k < 2 ? 0 : k > 10 ? 9 : k - 1));
      end
      // A held over-level lights the over lamp while the step is still qualified.
      fork
         u_far.pulse(3, 8);
         begin
            repeat (5) @(posedge pclk);
            chk(disp[1:0], 2'b10);
         end
      join
      u_far.pulse(0, 5);
      repeat (5) @(posedge pclk);
      chk(dist_gain_lines, 8'h10);
      u_far.pulse(1, 5);
      repeat (5) @(posedge pclk);
      chk(dist_gain_lines, 8'h08);
      // Latch lines take over the panel filters; the selector reads back every input.
      panel.filter <= 4'($urandom);
      drive <= 4'($urandom);
      lat = 8'($urandom);
      @(posedge pclk);
      chk(filter_lines, panel.filter);
      for (int i = 0; i < 8; i++)
         apb(1'b1, `AGL_OFF_LATCH, {28'h0, lat[i], 3'(i)});
      apb(1'b0, `AGL_OFF_LATCH, 32'h0);
      chk(rd[7:0], lat);
      chk({drive_lines, filter_lines}, lat);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `AGL_OFF_SWSEL, i);
         apb(1'b0, `AGL_OFF_SWSEL, 32'h0);
         chk(rd[0], i < 4 ? lat[i] : drive[7 - i]);
      end
      // Address switch, memory decode edges, bus addressing and the octal register.
      // Address 31 would make the listen and talk commands read as unlisten and untalk.
      panel.bus_addr <= 5'($urandom_range(30));
      @(posedge pclk);
      apb(1'b0, `AGL_OFF_ADDRSW, 32'h0);
      chk(rd[4:0], panel.bus_addr);
      foreach (corner[j]) begin
         cpu_addr <= corner[j];
         @(posedge pclk);
         apb(1'b0, `AGL_OFF_MEMDEC, 32'h0);
         chk(rd[1:0], {corner[j] >= 16'hE000, corner[j] <= 16'h03FF});
         chk({rom_sel, ram_sel}, {corner[j] >= 16'hE000, corner[j] <= 16'h03FF});
      end
      foreach (bcmd[j]) begin
         bus_cmd <= bcmd[j] | (bcmd[j][4] ? 8'h00 : {3'h0, panel.bus_addr ^ 5'(j == 3)});
         bus_cmd_valid <= 1'b1;
         @(posedge pclk);
         bus_cmd_valid <= 1'b0;
         @(posedge pclk);
         chk({talker, listener}, bexp[j]);
      end
      lat = 8'($urandom);
      apb(1'b1, `AGL_OFF_OCTAL, {24'h0, lat});
      chk(ctrl_line_oe, lat);
      chk(ctrl_line_o, 8'h00);
      apb(1'b0, 12'h040, 32'h0);
      chk({err_q, rd}, 33'h1_0000_0000);
      final_report;
   end
endmodule
